// *** verilog/amd_pkg.sv ***
// amd_pkg: constants, types and length decode for the addressing mode decoder
package amd_pkg;

    // ------------------------------------------------------------
    // address spaces
    // ------------------------------------------------------------
    localparam int unsigned PC_W        = 12;
    localparam int unsigned STACK_DEPTH = 6;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [2:0] SP_RESET     = 3'h0;
    localparam logic [2:0] SP_FULL      = 3'h6;
    localparam logic [7:0] PTR_ONE_ADDR = 8'h80;
    localparam logic [7:0] PTR_TWO_ADDR = 8'h81;
    localparam logic [7:0] SREG3_ADDR   = 8'h82;
    localparam logic [7:0] SREG4_ADDR   = 8'h83;
    localparam logic [7:0] ACC_ADDR     = 8'hFF;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // ------------------------------------------------------------
    // opcode map
    // ------------------------------------------------------------
    localparam logic [1:0] CLS_JUMP  = 2'h0;
    localparam logic [1:0] CLS_BIT   = 2'h1;
    localparam logic [1:0] CLS_ACC   = 2'h2;
    localparam logic [1:0] CLS_SHORT = 2'h3;
    localparam logic [1:0] MODE_IMM  = 2'h0;
    localparam logic [1:0] MODE_DIR  = 2'h1;
    localparam logic [1:0] MODE_IND  = 2'h2;
    localparam logic [1:0] OP_LOAD   = 2'h0;
    localparam logic [1:0] OP_STORE  = 2'h1;
    localparam logic [1:0] OP_ADD    = 2'h2;
    localparam logic [1:0] OP_AND    = 2'h3;
    localparam logic [7:0] OPC_LDI   = 8'h70;
    localparam logic [7:0] OPC_RET   = 8'h71;
    localparam logic [7:0] OPC_NOP   = 8'h72;
    localparam logic [7:0] OPC_COM   = 8'h73;

    typedef enum logic [2:0] {
        S_FETCH,
        S_PWAIT,
        S_PCAP,
        S_DATA,
        S_DWAIT,
        S_DCAP,
        S_EXEC
    } amd_state_t;

    typedef struct packed {
        logic [PC_W-1:0] addr;
        logic            rd;
    } amd_pm_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       rd;
        logic       wr;
    } amd_ds_req_t;

    // instruction length in bytes from the opcode alone
    function automatic logic [1:0] amd_len(input logic [7:0] op);
        logic [1:0] len;
        len = 2'd1;
        if (op[7])
            len = 2'd1;
        else if (op[6:5] == CLS_JUMP)
            len = 2'd2;
        else if (op[6:5] == CLS_BIT)
            len = op[4] ? 2'd3 : 2'd2;
        else if (op[6:5] == CLS_ACC)
            len = (op[1:0] == MODE_IMM || op[1:0] == MODE_DIR) ? 2'd2 : 2'd1;
        else if (op == OPC_LDI)
            len = 2'd3;
        return len;
    endfunction

endpackage

// *** verilog/amd_decoder.sv ***
// amd_decoder: addressing mode decoder and operand address former
`timescale 1ns/1ps
module amd_decoder
    import amd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    output amd_pm_req_t      pm_req,
    input  wire logic [7:0]  pm_data,
    output amd_ds_req_t      ds_req,
    input  wire logic [7:0]  ds_rdata,
    output logic [PC_W-1:0]  pc_out,
    output logic [7:0]       acc_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    amd_state_t      state_r;
    amd_state_t      state_nxt;
    amd_pm_req_t     pm_req_r;
    amd_pm_req_t     pm_req_nxt;
    amd_ds_req_t     ds_req_r;
    amd_ds_req_t     ds_req_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [7:0]      acc_r;
    logic [7:0]      acc_nxt;
    logic            z_r;
    logic            z_nxt;
    logic            c_r;
    logic            c_nxt;
    logic [7:0]      opc_r;
    logic [7:0]      b1_r;
    logic [7:0]      b2_r;
    logic [7:0]      opnd_r;
    logic [1:0]      idx_r;
    logic [7:0]      wreg_r [4];
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [2:0]      sp_r;

    // ------------------------------------------------------------
    // opcode classification
    // ------------------------------------------------------------
    wire [7:0] cur_op   = (idx_r == 2'd0) ? pm_data : opc_r;
    wire [1:0] cur_len  = amd_len(cur_op);
    wire [1:0] ins_len  = amd_len(opc_r);
    wire [1:0] cls      = opc_r[6:5];
    wire [1:0] mode     = opc_r[1:0];
    wire [1:0] aop      = opc_r[3:2];
    wire [2:0] bit_sel  = opc_r[2:0];
    wire is_rel   = opc_r[7];
    wire is_jmp   = !is_rel && cls == CLS_JUMP;
    wire is_call  = is_jmp && opc_r[4];
    wire is_bdir  = !is_rel && cls == CLS_BIT && !opc_r[4];
    wire is_btst  = !is_rel && cls == CLS_BIT && opc_r[4];
    wire is_acc   = !is_rel && cls == CLS_ACC && mode != 2'h3;
    wire is_short = !is_rel && cls == CLS_SHORT && !opc_r[4];
    wire is_ldi   = opc_r == OPC_LDI;
    wire is_ret   = opc_r == OPC_RET;
    wire is_com   = opc_r == OPC_COM;
    wire is_aluop = is_acc || is_short;

    // ------------------------------------------------------------
    // effective address
    // ------------------------------------------------------------
    // short register select
    wire [7:0] short_ea = PTR_ONE_ADDR | {6'h00, opc_r[1:0]};
    wire [7:0] ind_ea   = wreg_r[{1'b0, opc_r[4]}];
    wire [7:0] ea = is_short ? short_ea
                  : (is_acc && mode == MODE_IND) ? ind_ea
                  : b1_r;
    wire ea_wreg  = ea[7:2] == PTR_ONE_ADDR[7:2];
    wire ea_acc   = ea == ACC_ADDR;
    wire ea_int   = ea_wreg || ea_acc;
    wire [7:0] int_rd = ea_acc ? acc_r : wreg_r[ea[1:0]];
    wire needs_rd = is_bdir || is_btst
                  || (is_acc && mode != MODE_IMM && aop != OP_STORE)
                  || (is_short && aop != OP_STORE);
    wire [7:0] opnd = (is_acc && mode == MODE_IMM) ? b1_r : opnd_r;

    // ------------------------------------------------------------
    // execution
    // ------------------------------------------------------------
    logic [7:0]      wr_val;
    logic            wr_en;
    logic            push;
    logic            pop;
    logic [8:0]      sum;
    logic            cond;
    logic [PC_W-1:0] seq_pc;

    always_comb
    begin
        acc_nxt = acc_r;
        z_nxt   = z_r;
        c_nxt   = c_r;
        seq_pc  = pc_r + {{(PC_W-2){1'b0}}, ins_len};
        pc_nxt  = seq_pc;
        wr_en   = 1'b0;
        wr_val  = acc_r;
        push    = 1'b0;
        pop     = 1'b0;
        sum     = {1'b0, acc_r} + {1'b0, opnd};
        cond    = 1'b0;
        if (is_rel)
        begin
            cond = (opc_r[6] ? c_r : z_r) == opc_r[5];
            if (cond)
                pc_nxt = opc_r[4] ? pc_r - {8'h00, opc_r[3:0]}
                                  : pc_r + 12'h001 + {8'h00, opc_r[3:0]};
        end
        else if (is_jmp)
        begin
            pc_nxt = {opc_r[3:0], b1_r};
            push   = is_call;
        end
        else if (is_bdir)
        begin
            c_nxt  = opnd_r[bit_sel];
            wr_en  = 1'b1;
            wr_val = opnd_r;
            wr_val[bit_sel] = !opc_r[3];
        end
        else if (is_btst)
        begin
            c_nxt = opnd_r[bit_sel];
            cond  = opnd_r[bit_sel] == opc_r[3];
            if (cond)
                pc_nxt = pc_r + 12'h002 + {{4{b2_r[7]}}, b2_r};
        end
        else if (is_aluop)
        begin
            case (aop)
                OP_LOAD:
                begin
                    acc_nxt = opnd;
                    z_nxt   = opnd == 8'h00;
                end
                OP_STORE:
                begin
                    wr_en  = !(is_acc && mode == MODE_IMM);
                    wr_val = acc_r;
                end
                OP_ADD:
                begin
                    acc_nxt = sum[7:0];
                    c_nxt   = sum[8];
                    z_nxt   = sum[7:0] == 8'h00;
                end
                default:
                begin
                    acc_nxt = acc_r & opnd;
                    z_nxt   = (acc_r & opnd) == 8'h00;
                end
            endcase
        end
        else if (is_ldi)
        begin
            wr_en  = 1'b1;
            wr_val = b2_r;
        end
        else if (is_ret)
        begin
            pop = 1'b1;
            if (sp_r != SP_RESET)
                pc_nxt = stack_r[sp_r - 3'd1];
        end
        else if (is_com)
        begin
            acc_nxt = ~acc_r;
            z_nxt   = acc_r == 8'hFF;
        end
        if (wr_en && ea_acc)
            acc_nxt = wr_val;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt  = state_r;
        pm_req_nxt = '{addr: pm_req_r.addr, rd: 1'b0};
        ds_req_nxt = '{addr: ds_req_r.addr, wdata: ds_req_r.wdata, rd: 1'b0, wr: 1'b0};
        case (state_r)
            S_FETCH:
            begin
                pm_req_nxt = '{addr: pc_r, rd: 1'b1};
                state_nxt  = S_PWAIT;
            end
            S_PWAIT:
                state_nxt = S_PCAP;
            S_PCAP:
            begin
                if (idx_r + 2'd1 < cur_len)
                begin
                    pm_req_nxt = '{addr: pc_r + {{(PC_W-2){1'b0}}, idx_r + 2'd1}, rd: 1'b1};
                    state_nxt  = S_PWAIT;
                end
                else
                    state_nxt = S_DATA;
            end
            S_DATA:
            begin
                if (needs_rd)
                begin
                    ds_req_nxt = '{addr: ea, wdata: ds_req_r.wdata, rd: !ea_int, wr: 1'b0};
                    state_nxt  = S_DWAIT;
                end
                else
                    state_nxt = S_EXEC;
            end
            S_DWAIT:
                state_nxt = S_DCAP;
            S_DCAP:
                state_nxt = S_EXEC;
            default:
            begin
                if (wr_en && !ea_int)
                    ds_req_nxt = '{addr: ea, wdata: wr_val, rd: 1'b0, wr: 1'b1};
                state_nxt = S_FETCH;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r  <= S_FETCH;
            pm_req_r <= '{addr: PC_RESET, rd: 1'b0};
            ds_req_r <= '{addr: REG_RESET, wdata: REG_RESET, rd: 1'b0, wr: 1'b0};
            pc_r     <= PC_RESET;
            acc_r    <= REG_RESET;
            z_r      <= 1'b0;
            c_r      <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            pm_req_r <= pm_req_nxt;
            ds_req_r <= ds_req_nxt;
            if (state_r == S_EXEC)
            begin
                pc_r  <= pc_nxt;
                acc_r <= acc_nxt;
                z_r   <= z_nxt;
                c_r   <= c_nxt;
            end
        end
    end

    // instruction bytes and operand capture
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opc_r  <= OPC_NOP;
            b1_r   <= REG_RESET;
            b2_r   <= REG_RESET;
            opnd_r <= REG_RESET;
            idx_r  <= 2'd0;
        end
        else
        begin
            if (state_r == S_PCAP)
            begin
                case (idx_r)
                    2'd0:    opc_r <= pm_data;
                    2'd1:    b1_r  <= pm_data;
                    default: b2_r  <= pm_data;
                endcase
                idx_r <= (idx_r + 2'd1 < cur_len) ? idx_r + 2'd1 : 2'd0;
            end
            if (state_r == S_DCAP)
                opnd_r <= ea_int ? int_rd : ds_rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 4; i++)
                wreg_r[i] <= REG_RESET;
        end
        else if (state_r == S_EXEC && wr_en && ea_wreg)
            wreg_r[ea[1:0]] <= wr_val;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sp_r <= SP_RESET;
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_r[i] <= PC_RESET;
        end
        else if (state_r == S_EXEC)
        begin
            if (push && sp_r != SP_FULL)
            begin
                stack_r[sp_r] <= seq_pc;
                sp_r          <= sp_r + 3'd1;
            end
            else if (pop && sp_r != SP_RESET)
                sp_r <= sp_r - 3'd1;
        end
    end

    assign pm_req  = pm_req_r;
    assign ds_req  = ds_req_r;
    assign pc_out  = pc_r;
    assign acc_out = acc_r;

endmodule

// *** verification/amd_decoder_monitor.sv ***
// amd_decoder_chk: port assertions for the addressing mode decoder
`timescale 1ns/1ps
module amd_decoder_chk
    import amd_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_b,
    input amd_pm_req_t          pm_req,
    input wire logic [7:0]      pm_data,
    input amd_ds_req_t          ds_req,
    input wire logic [7:0]      ds_rdata,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic [7:0]      acc_out
);
    // ------------------------------------------------------------
    // instruction byte capture
    // ------------------------------------------------------------
    logic            pv;
    logic            dv;
    logic [7:0]      op_r;
    logic [7:0]      b1_r;
    logic [7:0]      b2_r;
    logic [7:0]      rd_r;
    logic [PC_W-1:0] ofs;
    logic [7:0]      msk;
    assign ofs = pm_req.addr - pc_out;
    assign msk = 8'h01 << op_r[2:0];
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pv   <= 1'b0;
            dv   <= 1'b0;
            op_r <= OPC_NOP;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            rd_r <= 8'h00;
        end
        else
        begin
            pv <= pm_req.rd;
            dv <= ds_req.rd;
            if (pv && ofs == 12'h000)
                op_r <= pm_data;
            if (pv && ofs == 12'h001)
                b1_r <= pm_data;
            if (pv && ofs == 12'h002)
                b2_r <= pm_data;
            if (dv)
                rd_r <= ds_rdata;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    chk_pm_pulse:
        assert property (pm_req.rd |=> !pm_req.rd)
        else $error("program strobe too long");
    chk_ds_internal:
        assert property ((ds_req.rd || ds_req.wr) |-> !(ds_req.addr inside {[8'h80:8'h83], 8'hFF}))
        else $error("strobe on internal address");
    chk_dir_addr:
        assert property (ds_req.rd && op_r[7:5] == 3'h2 && op_r[1:0] == MODE_DIR |-> ds_req.addr == b1_r)
        else $error("direct address wrong");
    chk_imm_load:
        assert property ($changed(pc_out) && op_r[7:5] == 3'h2 && op_r[3:0] == 4'h0 |-> ##[0:2] acc_out == b1_r)
        else $error("immediate load wrong");
    chk_ext_target:
        assert property ($changed(pc_out) && op_r[7:5] == 3'h0 |-> pc_out == {op_r[3:0], b1_r})
        else $error("extended target wrong");
    chk_rel_span:
        assert property ($changed(pc_out) && op_r[7] |-> pc_out == $past(pc_out) + 12'h001
            || pc_out == (op_r[4] ? $past(pc_out) - op_r[3:0] : $past(pc_out) + 12'h001 + op_r[3:0]))
        else $error("relative target wrong");
    chk_bit_write:
        assert property (ds_req.wr && op_r[7:4] == 4'h2 |-> ds_req.wdata == (op_r[3] ? rd_r & ~msk : rd_r | msk))
        else $error("bit write-back wrong");
    chk_ldi_write:
        assert property (ds_req.wr && op_r == OPC_LDI |-> ds_req.addr == b1_r && ds_req.wdata == b2_r)
        else $error("immediate store wrong");

    cov_write: cover property (ds_req.wr);
    cov_call: cover property ($changed(pc_out) && op_r[7:4] == 4'h1);
    cov_dir: cover property (ds_req.rd && op_r[1:0] == MODE_DIR);
    cov_rel: cover property ($changed(pc_out) && op_r[7]);
endmodule

bind amd_decoder amd_decoder_chk chk_u (.clk(clk), .rst_b(rst_b), .pm_req(pm_req), .pm_data(pm_data),
    .ds_req(ds_req), .ds_rdata(ds_rdata), .pc_out(pc_out), .acc_out(acc_out));

// *** verification/amd_mem_model.sv ***
// amd_mem_model: program memory and data space facing the decoder
`timescale 1ns/1ps
module amd_mem_model
    import amd_pkg::*;
(
    input wire logic   clk,
    input amd_pm_req_t pm_req,
    output logic [7:0] pm_data,
    input amd_ds_req_t ds_req,
    output logic [7:0] ds_rdata
);
    logic [7:0] prog [0:4095];
    logic [7:0] dmem [0:255];

    initial
    begin
        pm_data = 8'h00;
        ds_rdata = 8'h00;
        foreach (dmem[i])
            dmem[i] = 8'h00;
    end

    // ------------------------------------------------------------
    // memories
    // ------------------------------------------------------------
    // opcode and immediate bytes
    always @(posedge clk)
    begin
        pm_data <= pm_req.rd ? prog[pm_req.addr] : ~pm_data;
    end

    always @(posedge clk)
    begin
        ds_rdata <= ds_req.rd ? dmem[ds_req.addr] : ~ds_rdata;
        if (ds_req.wr)
            dmem[ds_req.addr] <= ds_req.wdata;
    end
endmodule

// *** verification/tb_top.sv ***
// tb_top: scenario bench for the addressing mode decoder
`timescale 1ns/1ps
module tb_top;
    import amd_pkg::*;
    logic            clk;
    logic            rst_b;
    amd_pm_req_t     pm_req;
    amd_ds_req_t     ds_req;
    logic [7:0]      pm_data;
    logic [7:0]      ds_rdata;
    logic [PC_W-1:0] pc_out;
    logic [7:0]      acc_out;
    int              bad_count;
    int              checks_done;

    amd_decoder dut_u (.clk(clk), .rst_b(rst_b), .pm_req(pm_req), .pm_data(pm_data), .ds_req(ds_req),
        .ds_rdata(ds_rdata), .pc_out(pc_out), .acc_out(acc_out));
    amd_mem_model m_u (.clk(clk), .pm_req(pm_req), .pm_data(pm_data), .ds_req(ds_req), .ds_rdata(ds_rdata));

    initial
    begin
        clk = 1'b0;
        forever
            #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task load(input logic [255:0] v, input int n, input int base);
        for (int i = 0; i < n; i++)
            m_u.prog[base + i] = v[8 * (n - 1 - i) +: 8];
    endtask

    task start;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5)
            @(posedge clk);
        @(negedge clk);
        chk("reset_pc", 12'h000, pc_out);
        chk("reset_acc", 12'h000, {4'h0, acc_out});
        @(posedge clk);
        rst_b <= 1'b1;
    endtask

    task run_to(input logic [11:0] halt);
        int n;
        n = 0;
        while (pc_out !== halt && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        chk("halt_pc", halt, pc_out);
        if (n >= 3000)
            report_and_stop();
        else
            repeat (4)
                @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task sc_modes;
        load(128'h405A45307031C341317348104C0F03A5, 16, 0);
        load(16'h03A5, 2, 12'h3A5);
        start();
        run_to(12'h3A5);
        chk("acc", 12'h00C, {4'h0, acc_out});
        chk("store_dir", 12'h05A, {4'h0, m_u.dmem[8'h30]});
        chk("ldi", 12'h0C3, {4'h0, m_u.dmem[8'h31]});
    endtask

    task sc_regs;
        load(232'h4090644091657090117091224245405266400062454123502951E17390, 29, 0);
        m_u.dmem[8'h50] = 8'h00;
        m_u.dmem[8'h51] = 8'hFF;
        start();
        run_to(12'h01C);
        chk("acc", 12'h022, {4'h0, acc_out});
        chk("ind_one", 12'h011, {4'h0, m_u.dmem[8'h40]});
        chk("short", 12'h022, {4'h0, m_u.dmem[8'h41]});
        chk("bit_set", 12'h008, {4'h0, m_u.dmem[8'h50]});
        chk("bit_lower", 12'h0FD, {4'h0, m_u.dmem[8'h51]});
    endtask

    task sc_flow;
        load(136'h4245614000A340EE721020A5456038600E, 17, 0);
        load(40'h9000400171, 5, 12'h01E);
        m_u.dmem[8'h00] = 8'h5E;
        start();
        run_to(12'h01E);
        chk("acc", 12'h001, {4'h0, acc_out});
        chk("ret_store", 12'h001, {4'h0, m_u.dmem[8'h60]});
        chk("ptr_reset", 12'h05E, {4'h0, m_u.dmem[8'h61]});
    endtask

    initial
    begin
        rst_b = 1'b0;
        bad_count = 0;
        checks_done = 0;
        sc_modes();
        sc_regs();
        sc_flow();
        report_and_stop();
    end
endmodule
